// ===== logic/guest_irq_defines.svh
// register offsets, field positions, reset values and counts for the guest interrupt block
`ifndef GUEST_IRQ_DEFINES_SVH
`define GUEST_IRQ_DEFINES_SVH

// byte offsets on the register bus
`define OFS_PRIMARY_CTL   6'h00
`define OFS_INT_CTL       6'h04
`define OFS_GUEST_CAUSE   6'h08
`define OFS_ROOT_CAUSE    6'h0c
`define OFS_ROOT_STATUS   6'h10
`define OFS_GUEST_STATUS  6'h14
`define OFS_GUEST_INTCFG  6'h18
`define OFS_ROOT_COUNT    6'h1c
`define OFS_ROOT_COMPARE  6'h20
`define OFS_GUEST_COUNT   6'h24
`define OFS_GUEST_COMPARE 6'h28
`define OFS_TAKE_STATUS   6'h2c

// field positions
`define LINES             6
`define PEND_W            8
`define LINE_BASE         2
`define PRI_W             6
`define CTL_ROOT_EIC      8
`define CTL_GUEST_EIC     9
`define CTL_GUEST_MODE    10
`define ICTL_HC_LSB       8
`define ICTL_GRPL_LSB     16
`define STAT_IE           8
`define CFG_BEV           0
`define CFG_IV            1
`define CFG_VS_LSB        2
`define CFG_VS_W          5
`define CFG_TLS_LSB       8
`define CFG_CLS_LSB       12
`define CFG_FIELD_W       7

// reset values and the fixed root timer line
`define ROOT_TIMER_LINE   3'h7
`define TLS_RESET         3'h7
`define CLS_RESET         3'h6
`define HC_PRESET         6'h00

`endif

// ===== logic/guest_irq_pkg.sv
// types shared by the guest interrupt virtualization block
package guest_irq_pkg;

   typedef struct packed {
      logic       guest_mode;
      logic       guest_eic;
      logic       root_eic;
      logic [5:0] pending_passthrough_mask;
   } primary_ctl_s;

   typedef struct packed {
      logic [2:0] counter_line_select;
      logic [2:0] timer_line_select;
      logic [4:0] vector_spacing;
      logic       special_vector_enable;
      logic       boot_vector_select;
   } guest_intcfg_s;

   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_ack  = 2'b01
   } bus_state_e;

endpackage

// ===== logic/guest_irq_virtualization.sv
// root and guest interrupt routing, virtual injection and timers behind an avalon slave
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`include "guest_irq_defines.svh"

// Overview of operation
// - root interrupt evaluation always runs, also in guest mode; guest cannot disable it.
// - root-enabled interrupts taken in root; root-masked guest-enabled ones taken in guest.
// - with both eligible, the root interrupt is taken first.
// - guest pending is OR of passthrough lines, guest sources and root-injected bits.
// - root and guest each have a timer with its own interrupt.
// - root cause writes and direct line assignment work together.
// - non-controller mode: guest timer drives bit chosen by timer line select.
// - guest software interrupts ignore passthrough and, in non-controller mode, use counter line select bit.
// - six external interrupt lines 5..0 shared by both contexts.
// - passthrough bit n routes line n to guest bit n+2, else root bit n+2.
// - guest bit n+2 = (line n and passthrough n) or virtual pending n.
// - root bit n+2 = line n and not (passthrough n or (virtual n and hw-clear n)).
// - with hw-clear n set, line n falling clears virtual pending n.
// - root writing 1 to a virtual bit injects, writing 0 withdraws.
// - virtual and hw-clear support are optional, hw-clear present if writable or preset.
// - without virtual bits a hidden shadow is set by root writes to guest cause, cleared by falls.
// - with virtual bits there is no shadow; guest cause writes to bits 7:2 ignored.
// - guest changes of vector select, vector enable, spacing raise a field-change exception.
module guest_irq_virtualization #(
   parameter bit             virt_present = 1'b1,
   parameter bit             hc_writable  = 1'b1,
   parameter logic [5:0]     hc_preset    = `HC_PRESET
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // avalon-mm slave
   input  wire logic [5:0]   address,
   input  wire logic         read,
   input  wire logic         write,
   input  wire logic [31:0]  writedata,
   input  wire logic [3:0]   byteenable,
   output logic [31:0]       readdata,
   output logic              waitrequest,
   input  wire logic         guest_access,
   // external interrupt pins
   input  wire logic [5:0]   ext_irq_lines,
   // controller-mode priority levels
   input  wire logic [5:0]   root_requested_priority_level,
   input  wire logic [5:0]   guest_requested_priority_level,
   input  wire logic         root_bus_for_guest,
   // results to the core
   output logic [7:0]        root_pending_field,
   output logic [7:0]        guest_pending_field,
   output logic              root_irq_take,
   output logic              guest_irq_take,
   output logic              field_change_exc
);

   // line select decode to a one-hot pending vector
   function automatic logic [7:0] line_onehot(input logic [2:0] sel);
      line_onehot = 8'h01 << sel;
   endfunction

   // byte-enable merge of a write into an old word
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      be_merge = r;
   endfunction

   guest_irq_pkg::bus_state_e    bus_state;
   guest_irq_pkg::primary_ctl_s  ctl;
   guest_irq_pkg::guest_intcfg_s gcfg;
   logic [5:0]  virtual_pending_bits;
   logic [5:0]  hw_clear_enable;
   logic [5:0]  captured_guest_priority_level;
   logic [1:0]  guest_sw_irq;
   logic [1:0]  root_sw_irq;
   logic [7:0]  root_line_mask;
   logic [7:0]  guest_line_mask;
   logic        root_ie;
   logic        guest_ie;
   logic [31:0] root_count;
   logic [31:0] root_compare;
   logic [31:0] guest_count;
   logic [31:0] guest_compare;
   logic        root_timer_irq;
   logic        guest_timer_irq;
   logic [5:0]  line_sync1;
   logic [5:0]  line_sync2;
   logic [5:0]  line_prev;
   logic [5:0]  line_fall;
   logic        wr_now;
   logic        rd_now;
   logic        wr_root;
   logic [31:0] wword;
   logic [31:0] ctl_word;
   logic [31:0] ctl_wr;
   logic [7:0]  next_root_pending;
   logic [7:0]  next_guest_pending;
   logic        root_eligible;
   logic        guest_eligible;
   logic [31:0] next_readdata;
   guest_irq_pkg::guest_intcfg_s next_gcfg;

   // avalon handshake: one wait cycle, answer with waitrequest low for one cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_state   <= guest_irq_pkg::bus_idle;
         waitrequest <= 1'b1;
      end else begin
         case (bus_state)
            guest_irq_pkg::bus_idle: begin
               if (read || write) begin
                  bus_state   <= guest_irq_pkg::bus_ack;
                  waitrequest <= 1'b0;
               end
            end
            guest_irq_pkg::bus_ack: begin
               bus_state   <= guest_irq_pkg::bus_idle;
               waitrequest <= 1'b1;
            end
            default: begin
               bus_state   <= guest_irq_pkg::bus_idle;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   assign wr_now  = write && (bus_state == guest_irq_pkg::bus_ack);
   assign rd_now  = read && (bus_state == guest_irq_pkg::bus_idle);
   // guest side may not touch root controls
   assign wr_root = wr_now && !guest_access;

   // pin synchroniser and fall detect behind the second stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         line_sync1 <= 6'h00;
         line_sync2 <= 6'h00;
         line_prev  <= 6'h00;
      end else begin
         line_sync1 <= ext_irq_lines;
         line_sync2 <= line_sync1;
         line_prev  <= line_sync2;
      end
   end

   assign line_fall = line_prev & ~line_sync2;

   // primary control as software sees it; bits 7:6 and 31:11 read zero
   assign ctl_word = {21'h0, ctl.guest_mode, ctl.guest_eic, ctl.root_eic, 2'h0, ctl.pending_passthrough_mask};
   assign ctl_wr   = be_merge(ctl_word, writedata, byteenable);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl <= '0;
      end else if (wr_root && address == `OFS_PRIMARY_CTL) begin
         ctl.guest_mode               <= ctl_wr[`CTL_GUEST_MODE];
         ctl.guest_eic                <= ctl_wr[`CTL_GUEST_EIC];
         ctl.root_eic                 <= ctl_wr[`CTL_ROOT_EIC];
         ctl.pending_passthrough_mask <= ctl_wr[`LINES-1:0];
      end
   end

   // virtual pending bits or, without virtual support, the hidden shadow copy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         virtual_pending_bits <= 6'h00;
      end else begin
         logic [5:0] v;
         v = virtual_pending_bits;
         if (virt_present) begin
            if (wr_root && address == `OFS_INT_CTL && byteenable[0]) begin
               v = writedata[5:0];
            end
            v = v & ~(line_fall & hw_clear_enable);
         end else begin
            if (wr_root && address == `OFS_GUEST_CAUSE && byteenable[0]) begin
               v = writedata[7:2];
            end
            v = v & ~line_fall;
         end
         virtual_pending_bits <= v;
      end
   end

   // hardware-clear enables, optional and possibly preset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hw_clear_enable <= hc_preset;
      end else if (virt_present && hc_writable && wr_root && address == `OFS_INT_CTL && byteenable[1]) begin
         hw_clear_enable <= writedata[`ICTL_HC_LSB +: 6];
      end
   end

   // captured guest priority level: root write or capture from the root bus
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         captured_guest_priority_level <= 6'h00;
      end else if (wr_root && address == `OFS_INT_CTL && byteenable[2]) begin
         captured_guest_priority_level <= writedata[`ICTL_GRPL_LSB +: 6];
      end else if (ctl.root_eic && root_bus_for_guest && root_requested_priority_level != 6'h00) begin
         captured_guest_priority_level <= root_requested_priority_level;
      end
   end

   // software interrupt bits of both contexts
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         guest_sw_irq <= 2'h0;
         root_sw_irq  <= 2'h0;
      end else begin
         if (wr_now && address == `OFS_GUEST_CAUSE && byteenable[0]) begin
            guest_sw_irq <= writedata[1:0];
         end
         if (wr_root && address == `OFS_ROOT_CAUSE && byteenable[0]) begin
            root_sw_irq <= writedata[1:0];
         end
      end
   end

   // status masks and enables
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         root_line_mask  <= 8'h00;
         root_ie         <= 1'b0;
         guest_line_mask <= 8'h00;
         guest_ie        <= 1'b0;
      end else begin
         if (wr_root && address == `OFS_ROOT_STATUS) begin
            if (byteenable[0]) begin
               root_line_mask <= writedata[7:0];
            end
            if (byteenable[1]) begin
               root_ie <= writedata[`STAT_IE];
            end
         end
         if (wr_now && address == `OFS_GUEST_STATUS) begin
            if (byteenable[0]) begin
               guest_line_mask <= writedata[7:0];
            end
            if (byteenable[1]) begin
               guest_ie <= writedata[`STAT_IE];
            end
         end
      end
   end

   // guest interrupt configuration; guest-made changes to bits 6:0 trap to root
   always_comb begin
      wword     = 32'h0;
      next_gcfg = gcfg;
      if (wr_now && address == `OFS_GUEST_INTCFG) begin
         wword     = be_merge({17'h0, gcfg.counter_line_select, 1'b0, gcfg.timer_line_select, 1'b0,
                               gcfg.vector_spacing, gcfg.special_vector_enable, gcfg.boot_vector_select},
                              writedata, byteenable);
         next_gcfg = {wword[`CFG_CLS_LSB +: 3], wword[`CFG_TLS_LSB +: 3], wword[`CFG_FIELD_W-1:0]};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gcfg             <= '{counter_line_select: `CLS_RESET, timer_line_select: `TLS_RESET, default: '0};
         field_change_exc <= 1'b0;
      end else begin
         gcfg             <= next_gcfg;
         field_change_exc <= guest_access && wr_now && (next_gcfg[`CFG_FIELD_W-1:0] != gcfg[`CFG_FIELD_W-1:0]);
      end
   end

   // root and guest timers; compare write clears, a hit in that cycle wins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         root_count     <= 32'h0;
         root_compare   <= 32'hffffffff;
         root_timer_irq <= 1'b0;
      end else begin
         root_count <= (wr_root && address == `OFS_ROOT_COUNT) ?
                       be_merge(root_count, writedata, byteenable) : root_count + 32'h1;
         if (wr_root && address == `OFS_ROOT_COMPARE) begin
            root_compare <= be_merge(root_compare, writedata, byteenable);
         end
         if (root_count == root_compare) begin
            root_timer_irq <= 1'b1;
         end else if (wr_root && address == `OFS_ROOT_COMPARE) begin
            root_timer_irq <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         guest_count     <= 32'h0;
         guest_compare   <= 32'hffffffff;
         guest_timer_irq <= 1'b0;
      end else begin
         guest_count <= (wr_now && address == `OFS_GUEST_COUNT) ?
                        be_merge(guest_count, writedata, byteenable) : guest_count + 32'h1;
         if (wr_now && address == `OFS_GUEST_COMPARE) begin
            guest_compare <= be_merge(guest_compare, writedata, byteenable);
         end
         if (guest_count == guest_compare) begin
            guest_timer_irq <= 1'b1;
         end else if (wr_now && address == `OFS_GUEST_COMPARE) begin
            guest_timer_irq <= 1'b0;
         end
      end
   end

   // pending field merge for both contexts
   always_comb begin
      logic [5:0] hc_eff;
      hc_eff             = virt_present ? hw_clear_enable : 6'h00;
      next_root_pending  = {line_sync2 & ~(ctl.pending_passthrough_mask
                                           | (virtual_pending_bits & hc_eff)), root_sw_irq};
      next_guest_pending = {(line_sync2 & ctl.pending_passthrough_mask) | virtual_pending_bits,
                            guest_sw_irq};
      if (root_timer_irq) begin
         next_root_pending = next_root_pending | line_onehot(`ROOT_TIMER_LINE);
      end
      if (!ctl.guest_eic) begin
         if (guest_timer_irq) begin
            next_guest_pending = next_guest_pending | line_onehot(gcfg.timer_line_select);
         end
         if (guest_sw_irq != 2'h0) begin
            next_guest_pending = next_guest_pending | line_onehot(gcfg.counter_line_select);
         end
      end
   end

   // take decision: root always evaluated first and wins
   always_comb begin
      if (ctl.root_eic) begin
         root_eligible = root_ie && root_requested_priority_level != 6'h00;
      end else begin
         root_eligible = root_ie && ((next_root_pending & root_line_mask) != 8'h00);
      end
      if (ctl.guest_eic) begin
         guest_eligible = guest_ie && (guest_requested_priority_level != 6'h00
                                       || captured_guest_priority_level != 6'h00);
      end else begin
         guest_eligible = guest_ie && ((next_guest_pending & guest_line_mask) != 8'h00);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         root_pending_field  <= 8'h00;
         guest_pending_field <= 8'h00;
         root_irq_take       <= 1'b0;
         guest_irq_take      <= 1'b0;
      end else begin
         root_pending_field  <= next_root_pending;
         guest_pending_field <= next_guest_pending;
         root_irq_take       <= root_eligible;
         guest_irq_take      <= guest_eligible && ctl.guest_mode && !root_eligible;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      case (address)
         `OFS_PRIMARY_CTL:   next_readdata = ctl_word;
         `OFS_INT_CTL:       next_readdata = virt_present ?
                                             {10'h0, captured_guest_priority_level, 2'h0, hw_clear_enable,
                                              2'h0, virtual_pending_bits} : 32'h0;
         `OFS_GUEST_CAUSE:   next_readdata = {24'h0, guest_pending_field};
         `OFS_ROOT_CAUSE:    next_readdata = {24'h0, root_pending_field};
         `OFS_ROOT_STATUS:   next_readdata = {23'h0, root_ie, root_line_mask};
         `OFS_GUEST_STATUS:  next_readdata = {23'h0, guest_ie, guest_line_mask};
         `OFS_GUEST_INTCFG:  next_readdata = {17'h0, gcfg.counter_line_select, 1'b0, gcfg.timer_line_select,
                                              1'b0, gcfg[`CFG_FIELD_W-1:0]};
         `OFS_ROOT_COUNT:    next_readdata = root_count;
         `OFS_ROOT_COMPARE:  next_readdata = root_compare;
         `OFS_GUEST_COUNT:   next_readdata = guest_count;
         `OFS_GUEST_COMPARE: next_readdata = guest_compare;
         `OFS_TAKE_STATUS:   next_readdata = {28'h0, guest_timer_irq, root_timer_irq, guest_irq_take,
                                              root_irq_take};
         default:            next_readdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readdata <= 32'h0;
      end else if (rd_now) begin
         readdata <= next_readdata;
      end
   end

endmodule

// ===== verification/guest_irq_checker_assertions.sv
// port-level timing and routing checks for the guest interrupt block
`include "guest_irq_defines.svh"
module guest_irq_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // register bus
   input wire logic [5:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic        guest_access,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // pins and results
   input wire logic [5:0]  ext_irq_lines,
   input wire logic [7:0]  root_pending_field,
   input wire logic        root_irq_take,
   input wire logic        guest_irq_take,
   input wire logic        field_change_exc
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_wait_answer: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
      else $error("bus request not answered in time");
   chk_wait_one: assert property ($fell(waitrequest) |=> waitrequest)
      else $error("acceptance lasted more than one cycle");
   chk_wait_idle: assert property (waitrequest && !read && !write |=> waitrequest)
      else $error("acceptance without a request");
   chk_read_hold: assert property (!read |=> $stable(readdata))
      else $error("read data moved without a read");
   // bits 7 and 1:0 have other sources, so only the line-only bits are tied to pins
   chk_root_line_cause: assert property ((root_pending_field[6:2]
      & ~($past(ext_irq_lines[4:0], 3) | $past(ext_irq_lines[4:0], 4))) == 5'h00)
      else $error("root pending bit without its pin");
   chk_root_over_guest: assert property (guest_irq_take |-> !root_irq_take)
      else $error("guest taken while root eligible");
   chk_fce_pulse: assert property (field_change_exc |=> !field_change_exc)
      else $error("field change pulse too long");
   chk_fce_cause: assert property (field_change_exc |->
      $past(write && guest_access && address == `OFS_GUEST_INTCFG, 1)
      || $past(write && guest_access && address == `OFS_GUEST_INTCFG, 2))
      else $error("field change pulse without a guest write");

   cov_root_take: cover property ($rose(root_irq_take));
   cov_guest_take: cover property ($rose(guest_irq_take));
   cov_fce: cover property (field_change_exc);
endmodule

bind guest_irq_virtualization guest_irq_checker i_chk (
   .clk                (clk),
   .rstn               (rstn),
   .address            (address),
   .read               (read),
   .write              (write),
   .guest_access       (guest_access),
   .readdata           (readdata),
   .waitrequest        (waitrequest),
   .ext_irq_lines      (ext_irq_lines),
   .root_pending_field (root_pending_field),
   .root_irq_take      (root_irq_take),
   .guest_irq_take     (guest_irq_take),
   .field_change_exc   (field_change_exc)
);

// ===== verification/ext_irq_source.sv
// behavioural source of the six external interrupt pins
module ext_irq_source (
   // clock
   input wire logic       clk,
   // levels asked for by the bench
   input wire logic [5:0] want,
   // pins towards the block
   output logic [5:0]     lines
);
   timeunit 1ns;
   timeprecision 1ps;
   initial lines = 6'h00;
   // a peripheral changes its level only after an edge, never mid-cycle
   always @(posedge clk) begin
      lines <= want;
   end
endmodule

// ===== verification/guest_irq_virtualization_tb.sv
// self-checking bench for the guest interrupt block
`include "guest_irq_defines.svh"
module guest_irq_virtualization_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [5:0]  address = 6'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic        guest_access = 1'b0;
   logic [5:0]  want = 6'h00;
   logic [5:0]  lines;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [7:0]  root_pend;
   logic [7:0]  guest_pend;
   logic        root_take;
   logic        guest_take;
   logic        fce;
   logic [31:0] rd;
   int          n_errors = 0;
   int          n_tests = 0;
   int          n_pulses = 0;

   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (fce === 1'b1) n_pulses <= n_pulses + 1;
   end

   ext_irq_source i_src (.clk(clk), .want(want), .lines(lines));
   guest_irq_virtualization i_dut (
      .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
      .guest_access(guest_access), .ext_irq_lines(lines),
      .root_requested_priority_level(6'h00), .guest_requested_priority_level(6'h00),
      .root_bus_for_guest(1'b0), .root_pending_field(root_pend), .guest_pending_field(guest_pend),
      .root_irq_take(root_take), .guest_irq_take(guest_take), .field_change_exc(fce));

   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one transfer; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic ga);
      @(posedge clk);
      address <= a;
      writedata <= d;
      guest_access <= ga;
      write <= wr;
      read <= !wr;
      // no cycle count assumed: a lost answer is left to the watchdog
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      guest_access <= 1'b0;
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
   endtask

   task automatic t_reset();
      bus(0, `OFS_PRIMARY_CTL, 0, 0);
      compare(rd, 32'h0);
      bus(0, `OFS_INT_CTL, 0, 0);
      compare(rd, 32'h0);
      bus(0, `OFS_GUEST_INTCFG, 0, 0);
      compare(rd, 32'h6700);
      bus(0, 6'h30, 0, 0);
      compare(rd, 32'h0);
      compare({root_pend, guest_pend}, 16'h0);
   endtask

   task automatic t_route();
      for (int n = 0; n < 6; n++) begin
         want <= 6'(1 << n);
         bus(1, `OFS_PRIMARY_CTL, 0, 0);
         settle(5);
         compare({root_pend, guest_pend}, {8'(1 << (n + 2)), 8'h00});
         bus(1, `OFS_PRIMARY_CTL, 32'(1 << n), 0);
         settle(5);
         compare({root_pend, guest_pend}, {8'h00, 8'(1 << (n + 2))});
      end
      want <= 6'h00;
      bus(1, `OFS_PRIMARY_CTL, 0, 0);
      settle(5);
   endtask

   task automatic t_inject();
      bus(1, `OFS_INT_CTL, 32'h0101, 0);
      want <= 6'h01;
      settle(5);
      compare({root_pend, guest_pend}, 16'h0004);
      want <= 6'h00;
      settle(5);
      bus(0, `OFS_INT_CTL, 0, 0);
      compare(rd, 32'h0100);
      bus(1, `OFS_INT_CTL, 32'h0002, 0);
      want <= 6'h02;
      settle(5);
      compare({root_pend, guest_pend}, 16'h0808);
      want <= 6'h00;
      settle(5);
      bus(0, `OFS_INT_CTL, 0, 0);
      compare(rd, 32'h0002);
      bus(1, `OFS_INT_CTL, 0, 0);
      settle(2);
      compare(guest_pend, 8'h00);
   endtask

   task automatic t_soft();
      // upper bits must be dropped while virtual bits exist
      bus(1, `OFS_GUEST_CAUSE, 32'hfd, 0);
      bus(1, `OFS_PRIMARY_CTL, 32'h02, 0);
      want <= 6'h02;
      settle(5);
      compare(guest_pend, 8'h49);
      bus(1, `OFS_GUEST_CAUSE, 0, 0);
      bus(1, `OFS_PRIMARY_CTL, 0, 0);
      want <= 6'h00;
      settle(5);
      compare(guest_pend, 8'h00);
   endtask

   task automatic t_field();
      int p;
      p = n_pulses;
      bus(1, `OFS_GUEST_INTCFG, 32'h6701, 1);
      bus(1, `OFS_GUEST_INTCFG, 32'h6701, 1);
      bus(1, `OFS_GUEST_INTCFG, 32'h6700, 0);
      settle(3);
      compare(n_pulses - p, 1);
      bus(1, `OFS_PRIMARY_CTL, 32'h3f, 1);
      bus(0, `OFS_PRIMARY_CTL, 0, 0);
      compare(rd, 32'h0);
   endtask

   task automatic t_priority();
      bus(1, `OFS_ROOT_STATUS, 32'h1ff, 0);
      bus(1, `OFS_GUEST_STATUS, 32'h1ff, 0);
      bus(1, `OFS_PRIMARY_CTL, 32'h400, 0);
      bus(1, `OFS_INT_CTL, 32'h0002, 0);
      settle(4);
      compare({root_take, guest_take}, 2'b01);
      want <= 6'h01;
      settle(5);
      compare({root_take, guest_take}, 2'b10);
      want <= 6'h00;
      settle(5);
      compare({root_take, guest_take}, 2'b01);
   endtask

   // both timers restarted far below compare; each then lands on its own pending bit 7
   task automatic t_timer();
      bus(1, `OFS_ROOT_COMPARE, 32'h20, 0);
      bus(1, `OFS_GUEST_COMPARE, 32'h20, 0);
      bus(1, `OFS_ROOT_COUNT, 0, 0);
      bus(1, `OFS_GUEST_COUNT, 0, 0);
      settle(2);
      compare({root_pend, guest_pend}, 16'h0008);
      settle(40);
      compare({root_pend, guest_pend}, 16'h8088);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // whole sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_route();
      t_inject();
      t_soft();
      t_field();
      t_priority();
      t_timer();
      close_out();
   end
endmodule
